// File: verilog/pdwrr_ctrl.sv
// Host-side controller driving a 1M x 16 page-mode DRAM through its strobes
// Contract
// - Write strobe stays low past column fall; write pulse at least as long.
// - Write data valid by the later strobe fall and held afterwards.
// - Row and column strobes stay low after write strobe falls.
// - Plain write cycle meets minimum length; row low time within its window.
// - Read-modify-write cycle and its row low time meet their minimum lengths.
// - Output enable stays high after write strobe falls in read-modify-write.
// - Page column accesses keep minimum spacing, longer for read-write.
// - Column precharge between page accesses meets its minimum high time.
// - Short output enable or write pulse turns memory outputs off until next access.
// - Page write after read waits after column precharge and column fall.
// - Output enable rises only after column fall and address change delays.
// - Page read-write row low time covers two column cycles.
// - Refresh: column falls before row, stays low after row falls.
// - Begin with eight column-before-row cycles before refresh mode is used.
// - Hidden refresh may follow any read or write cycle type.
// - Self refresh: row held low long enough, then high long enough after exit.
// - Distributed refresh completes full row set before entry and after exit.
// - Burst refresh gaps around self refresh together stay under refresh period.
// - After long row strobe inactivity, issue eight row cycles before accesses.
module pdwrr_ctrl #(
    parameter int unsigned REF_CYC = pdwrr_pkg::C_REF,
    parameter bit SR_GRADE = 1'b1
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cken,
    // Access request
    input wire logic req_valid,
    output logic req_ready,
    input wire pdwrr_pkg::pdwrr_req_t req,
    // Read answer
    output logic rsp_valid,
    output logic [pdwrr_pkg::DQ_W-1:0] rsp_rdata,
    // Self refresh and status
    input wire logic self_refresh_req,
    output logic self_refresh_active,
    output logic init_done,
    // Memory pins
    output logic row_strobe_n,
    output logic upper_byte_col_strobe_n,
    output logic lower_byte_col_strobe_n,
    output logic write_strobe_n,
    output logic out_enable_n,
    output logic [pdwrr_pkg::ROW_W-1:0] mux_address,
    input wire logic [pdwrr_pkg::DQ_W-1:0] data_io_in,
    output logic [pdwrr_pkg::DQ_W-1:0] data_io_out,
    output logic data_io_oe
);

    typedef enum logic [3:0] {
        ST_INIT, ST_IDLE, ST_ROW, ST_ADDR, ST_COL, ST_CAS, ST_RMW_OE, ST_RMW_WR,
        ST_CAS_PRE, ST_RAS_PRE, ST_HID_PRE, ST_CBR_SET, ST_CBR_RAS, ST_SR_HOLD,
        ST_SR_EXIT
    } pdwrr_st_t;

    typedef struct packed {
        pdwrr_st_t st;
        pdwrr_pkg::pdwrr_pins_t pin;
        pdwrr_pkg::pdwrr_req_t cur;
        logic last_rd;
        logic [8:0] ras_cnt;
        logic [3:0] init_cnt;
        logic ref_pend;
        logic sr_act;
        logic rsp_valid;
        logic [pdwrr_pkg::DQ_W-1:0] rdata;
    } pdwrr_ctl_t;

    localparam int TW = 12;
    localparam logic [8:0] RAS_MIN = 9'(pdwrr_pkg::C_RAS_MIN);
    localparam logic [8:0] RAS_LIMIT = 9'(pdwrr_pkg::C_RAS_MAX - pdwrr_pkg::C_RAS_MARGIN);
    localparam logic [3:0] INIT_N = 4'(pdwrr_pkg::INIT_CBR);

    pdwrr_ctl_t s;
    pdwrr_ctl_t next_s;
    logic st_load;
    logic [TW-1:0] st_val;
    logic sdone;
    logic ref_done;
    logic ref_clr;
    logic ref_kick;
    logic cbr_go;
    logic fin;
    logic sr_go;
    logic page_hit;
    logic idle_ok;
    logic early_wr;

    // Dwell timer for every strobe phase
    pdwrr_timer #(.W(TW)) u_step (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cken(cken),
        .load(st_load),
        .load_val(st_val),
        .done(sdone)
    );

    // Distributed refresh spacing, reloads itself on expiry
    pdwrr_timer #(.W(TW)) u_ref (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cken(cken),
        .load(ref_done),
        .load_val(TW'(REF_CYC - 1)),
        .done(ref_done)
    );

    // Request acceptance terms; ready is combinational by design
    assign sr_go = SR_GRADE && self_refresh_req;
    assign early_wr = s.cur.write && !s.cur.rmw;
    assign idle_ok = (s.st == ST_IDLE) && !s.ref_pend && !sr_go;
    assign page_hit = (s.st == ST_CAS_PRE) && sdone && s.cur.keep_open && !s.ref_pend &&
                      !sr_go && (req.row == s.cur.row) && (s.ras_cnt < RAS_LIMIT);
    assign req_ready = idle_ok || page_hit;

    // Next-state logic for the whole strobe sequencer
    always_comb begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        st_load = 1'b0;
        st_val = '0;
        ref_clr = 1'b0;
        ref_kick = 1'b0;
        cbr_go = 1'b0;
        fin = 1'b0;
        // Row-low age, saturating, restarted at each row strobe fall
        if (!s.pin.row_strobe_n && (s.ras_cnt != '1)) begin
            next_s.ras_cnt = s.ras_cnt + 9'h001;
        end
        unique case (s.st)
            ST_INIT: begin
                cbr_go = 1'b1;
            end
            ST_IDLE: begin
                if (s.ref_pend) begin
                    cbr_go = 1'b1;
                end else if (sr_go) begin
                    next_s.sr_act = 1'b1;
                    cbr_go = 1'b1;
                end else if (req_valid) begin
                    next_s.cur = req;
                    next_s.pin.mux_address = req.row;
                    next_s.pin.row_strobe_n = 1'b0;
                    next_s.ras_cnt = '0;
                    st_load = 1'b1;
                    st_val = TW'(pdwrr_pkg::C_RCD - 1);
                    next_s.st = ST_ROW;
                end
            end
            ST_ROW: begin
                if (sdone) begin
                    next_s.st = ST_ADDR;
                end
            end
            ST_ADDR: begin
                // Column address one cycle ahead of the column strobe
                next_s.pin.mux_address = {{(pdwrr_pkg::ROW_W - pdwrr_pkg::COL_W){1'b0}}, s.cur.col};
                if (early_wr) begin
                    next_s.pin.write_strobe_n = 1'b0;
                    next_s.pin.data_io_out = s.cur.wdata;
                    next_s.pin.data_io_oe = 1'b1;
                end else begin
                    next_s.pin.out_enable_n = 1'b0;
                end
                next_s.st = ST_COL;
            end
            ST_COL: begin
                next_s.pin.lower_byte_col_strobe_n = !s.cur.byte_en[0];
                next_s.pin.upper_byte_col_strobe_n = !s.cur.byte_en[1];
                st_load = 1'b1;
                st_val = early_wr ? TW'(pdwrr_pkg::C_WR_CAS - 1) : TW'(pdwrr_pkg::C_RD_CAS - 1);
                next_s.st = ST_CAS;
            end
            ST_CAS: begin
                if (sdone) begin
                    if (!early_wr) begin
                        next_s.rdata = data_io_in;
                        next_s.rsp_valid = 1'b1;
                    end
                    if (s.cur.rmw && s.cur.write) begin
                        // Memory output must be off before we drive the bus
                        next_s.pin.out_enable_n = 1'b1;
                        st_load = 1'b1;
                        st_val = TW'(pdwrr_pkg::C_ODD - 1);
                        next_s.st = ST_RMW_OE;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            ST_RMW_OE: begin
                if (sdone) begin
                    next_s.pin.write_strobe_n = 1'b0;
                    next_s.pin.data_io_out = s.cur.wdata;
                    next_s.pin.data_io_oe = 1'b1;
                    st_load = 1'b1;
                    st_val = TW'(pdwrr_pkg::C_WP - 1);
                    next_s.st = ST_RMW_WR;
                end
            end
            ST_RMW_WR: begin
                if (sdone) begin
                    fin = 1'b1;
                end
            end
            ST_CAS_PRE: begin
                if (sdone) begin
                    if (page_hit && req_valid) begin
                        next_s.cur = req;
                        next_s.st = ST_ADDR;
                    end else if ((s.ras_cnt >= RAS_MIN) && (!s.cur.keep_open || s.ref_pend ||
                                 sr_go || req_valid || (s.ras_cnt >= RAS_LIMIT))) begin
                        next_s.pin.row_strobe_n = 1'b1;
                        st_load = 1'b1;
                        st_val = TW'(pdwrr_pkg::C_RP - 1);
                        next_s.st = ST_RAS_PRE;
                    end
                end
            end
            ST_RAS_PRE: begin
                if (sdone) begin
                    next_s.st = (s.init_cnt < INIT_N) ? ST_INIT : ST_IDLE;
                end
            end
            ST_HID_PRE, ST_CBR_SET: begin
                if (sdone) begin
                    next_s.pin.row_strobe_n = 1'b0;
                    next_s.ras_cnt = '0;
                    st_load = 1'b1;
                    st_val = s.sr_act ? TW'(pdwrr_pkg::C_SR - 1) : TW'(pdwrr_pkg::C_CBR_HOLD - 1);
                    next_s.st = ST_CBR_RAS;
                end
            end
            ST_CBR_RAS: begin
                if (sdone) begin
                    if (s.sr_act) begin
                        next_s.st = ST_SR_HOLD;
                    end else begin
                        // Count only finished cycles so init_done never leads the eighth
                        if (s.init_cnt < INIT_N) begin
                            next_s.init_cnt = s.init_cnt + 4'h1;
                        end
                        next_s.pin.row_strobe_n = 1'b1;
                        next_s.pin.lower_byte_col_strobe_n = 1'b1;
                        next_s.pin.upper_byte_col_strobe_n = 1'b1;
                        st_load = 1'b1;
                        st_val = TW'(pdwrr_pkg::C_RP - 1);
                        next_s.st = ST_RAS_PRE;
                    end
                end
            end
            ST_SR_HOLD: begin
                if (!sr_go) begin
                    next_s.pin.row_strobe_n = 1'b1;
                    next_s.pin.lower_byte_col_strobe_n = 1'b1;
                    next_s.pin.upper_byte_col_strobe_n = 1'b1;
                    st_load = 1'b1;
                    st_val = TW'(pdwrr_pkg::C_RPB - 1);
                    next_s.st = ST_SR_EXIT;
                end
            end
            ST_SR_EXIT: begin
                if (sdone) begin
                    next_s.sr_act = 1'b0;
                    ref_kick = 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
        endcase
        // End of an access: hidden refresh if one is owed, else column precharge
        if (fin) begin
            next_s.pin.write_strobe_n = 1'b1;
            next_s.pin.out_enable_n = 1'b1;
            next_s.pin.data_io_oe = 1'b0;
            next_s.last_rd = !s.cur.write;
            st_load = 1'b1;
            if (s.ref_pend) begin
                // Column strobes stay low while the row strobe cycles
                next_s.pin.row_strobe_n = 1'b1;
                next_s.pin.lower_byte_col_strobe_n = 1'b0;
                next_s.pin.upper_byte_col_strobe_n = 1'b0;
                st_val = TW'(pdwrr_pkg::C_RP - 1);
                ref_clr = 1'b1;
                next_s.st = ST_HID_PRE;
            end else begin
                next_s.pin.lower_byte_col_strobe_n = 1'b1;
                next_s.pin.upper_byte_col_strobe_n = 1'b1;
                // After a read the precharge is stretched so a page write may follow;
                // costs page read rate, saves tracking the next command type
                st_val = s.cur.write ? TW'(pdwrr_pkg::C_CP - 1) : TW'(pdwrr_pkg::C_HPWD - 1);
                next_s.st = ST_CAS_PRE;
            end
        end
        // Column strobes lead the row strobe for a refresh or self refresh entry
        if (cbr_go) begin
            next_s.pin.lower_byte_col_strobe_n = 1'b0;
            next_s.pin.upper_byte_col_strobe_n = 1'b0;
            next_s.pin.write_strobe_n = 1'b1;
            next_s.pin.out_enable_n = 1'b1;
            next_s.pin.data_io_oe = 1'b0;
            st_load = 1'b1;
            st_val = TW'(pdwrr_pkg::C_CSR - 1);
            ref_clr = 1'b1;
            next_s.st = ST_CBR_SET;
        end
        // A refresh tick in the clearing cycle still counts
        next_s.ref_pend = (s.ref_pend && !ref_clr) || ref_done || ref_kick;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= ST_INIT;
            s.pin <= pdwrr_pkg::PINS_RST;
        end else if (cken) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops; init_done compares the startup count
    assign rsp_valid = s.rsp_valid;
    assign rsp_rdata = s.rdata;
    assign self_refresh_active = s.sr_act;
    assign init_done = (s.init_cnt >= INIT_N);
    assign row_strobe_n = s.pin.row_strobe_n;
    assign upper_byte_col_strobe_n = s.pin.upper_byte_col_strobe_n;
    assign lower_byte_col_strobe_n = s.pin.lower_byte_col_strobe_n;
    assign write_strobe_n = s.pin.write_strobe_n;
    assign out_enable_n = s.pin.out_enable_n;
    assign mux_address = s.pin.mux_address;
    assign data_io_out = s.pin.data_io_out;
    assign data_io_oe = s.pin.data_io_oe;

endmodule : pdwrr_ctrl

// File: verilog/pdwrr_pkg.sv
// Shared constants, timing counts and carrier types for the page DRAM controller
package pdwrr_pkg;

    // Geometry of the attached memory
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int DQ_W = 16;
    localparam int INIT_CBR = 8;
    localparam int REF_ROWS = 4096;

    // Clock period and printed times (fast grade)
    localparam int T_CK_NS = 25;
    localparam int T_RCD_NS = 20;
    localparam int T_CSR_NS = 10;
    localparam int T_CHR_NS = 15;
    localparam int T_RAS_NS = 60;
    localparam int T_RAS_RMW_NS = 89;
    localparam int T_RAS_MAX_NS = 10000;
    localparam int T_RP_NS = 40;
    localparam int T_CP_NS = 10;
    localparam int T_HPWD_NS = 72;
    localparam int T_AA_NS = 30;
    localparam int T_CAS_NS = 10;
    localparam int T_DDD_NS = 15;
    localparam int T_WP_NS = 10;
    localparam int T_RPB_NS = 110;
    localparam int T_RASS_US = 100;
    localparam int T_REF_MS = 64;

    // Cycle counts: least times round up, longest times round down
    localparam int C_RCD = (T_RCD_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_CSR = (T_CSR_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_CHR = (T_CHR_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_RAS = (T_RAS_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_CBR_HOLD = (C_RAS > C_CHR) ? C_RAS : C_CHR;
    localparam int C_RAS_MIN = (T_RAS_RMW_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_RAS_MAX = T_RAS_MAX_NS / T_CK_NS;
    localparam int C_RP = (T_RP_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_CP = (T_CP_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_HPWD = (T_HPWD_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_RD_CAS = (T_AA_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_WR_CAS = (T_CAS_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_ODD = (T_DDD_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_WP = (T_WP_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_RPB = (T_RPB_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int C_SR = (T_RASS_US * 1000 + T_CK_NS - 1) / T_CK_NS;
    localparam int C_REF = (T_REF_MS * 1000000) / (REF_ROWS * T_CK_NS);
    // Page closes this many cycles before the row strobe limit
    localparam int C_RAS_MARGIN = 16;

    // Access request from the user side
    typedef struct packed {
        logic write;
        logic rmw;
        logic keep_open;
        logic [1:0] byte_en;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0] wdata;
    } pdwrr_req_t;

    // Memory-side pin image, all driven from flops
    typedef struct packed {
        logic row_strobe_n;
        logic upper_byte_col_strobe_n;
        logic lower_byte_col_strobe_n;
        logic write_strobe_n;
        logic out_enable_n;
        logic [ROW_W-1:0] mux_address;
        logic [DQ_W-1:0] data_io_out;
        logic data_io_oe;
    } pdwrr_pins_t;

    localparam pdwrr_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0, '0, 1'b0};

endpackage : pdwrr_pkg

// File: verilog/pdwrr_timer.sv
// Loadable down-counter used for strobe dwell times and refresh spacing
module pdwrr_timer #(
    parameter int W = 12
) (
    // Clock and control
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cken,
    // Load and status
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } pdwrr_tmr_t;

    pdwrr_tmr_t s;
    pdwrr_tmr_t next_s;

    // Count down to zero and rest there until reloaded
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.cnt = load_val;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
        end else if (cken) begin
            s <= next_s;
        end
    end

    assign done = (s.cnt == '0);

endmodule : pdwrr_timer

// File: dv/pdwrr_ctrl_properties.sv
// Pin timing checker for the page DRAM controller
module pdwrr_ctrl_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Status
    input wire logic self_refresh_active,
    input wire logic init_done,
    // Memory pins
    input wire logic row_strobe_n,
    input wire logic upper_byte_col_strobe_n,
    input wire logic lower_byte_col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic out_enable_n,
    input wire logic data_io_oe
);
    logic col_n;
    logic row_q;
    logic [3:0] n_row;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // High only while neither byte lane has a column access
    assign col_n = upper_byte_col_strobe_n & lower_byte_col_strobe_n;
    // Row strobe falls since reset; saturates so it never wraps
    always_ff @(posedge core_clk) begin
        row_q <= rst_b ? row_strobe_n : 1'b1;
        if (!rst_b) begin
            n_row <= 4'h0;
        end else if (row_q && !row_strobe_n && n_row != 4'hf) begin
            n_row <= n_row + 4'h1;
        end
    end
    property p_early_write;
        $fell(col_n) && !write_strobe_n |-> !$past(write_strobe_n);
    endproperty
    a_early_write: assert property (p_early_write) else $error("late write strobe");
    property p_write_row_hold;
        !write_strobe_n |-> !row_strobe_n;
    endproperty
    a_write_row_hold: assert property (p_write_row_hold) else $error("row rose early");
    property p_write_data;
        !write_strobe_n |-> data_io_oe;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data not driven");
    property p_rmw_oe;
        $fell(write_strobe_n) |-> out_enable_n ##1 out_enable_n;
    endproperty
    a_rmw_oe: assert property (p_rmw_oe) else $error("output enable low at write");
    property p_no_fight;
        data_io_oe |-> out_enable_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("data bus contention");
    property p_cbr;
        $fell(row_strobe_n) && !col_n |-> !$past(col_n) ##1 !col_n;
    endproperty
    a_cbr: assert property (p_cbr) else $error("refresh column order");
    property p_ras_min;
        $fell(row_strobe_n) |-> !row_strobe_n [*3];
    endproperty
    a_ras_min: assert property (p_ras_min) else $error("row low too short");
    property p_sr_exit;
        $rose(row_strobe_n) && self_refresh_active |-> row_strobe_n [*5];
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit short");
    property p_init;
        $rose(init_done) |-> n_row >= 4'h8;
    endproperty
    a_init: assert property (p_init) else $error("too few startup cycles");
endmodule : pdwrr_ctrl_properties

bind pdwrr_ctrl pdwrr_ctrl_properties u_pdwrr_ctrl_properties (
    .core_clk(core_clk), .rst_b(rst_b), .self_refresh_active(self_refresh_active),
    .init_done(init_done), .row_strobe_n(row_strobe_n),
    .upper_byte_col_strobe_n(upper_byte_col_strobe_n),
    .lower_byte_col_strobe_n(lower_byte_col_strobe_n), .write_strobe_n(write_strobe_n),
    .out_enable_n(out_enable_n), .data_io_oe(data_io_oe)
);

// File: dv/pdwrr_dram_model.sv
// Behavioural page-mode DRAM answering the controller's strobes
module pdwrr_dram_model (
    // Strobes
    input wire logic row_strobe_n,
    input wire logic upper_byte_col_strobe_n,
    input wire logic lower_byte_col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic out_enable_n,
    // Address and data
    input wire logic [11:0] mux_address,
    input wire logic [15:0] data_io_out,
    input wire logic data_io_oe,
    output logic [15:0] data_io_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [19:0]];
    logic [11:0] row = 12'h000;
    logic [7:0] col = 8'h00;
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    logic col_n;
    logic rd;
    assign col_n = upper_byte_col_strobe_n & lower_byte_col_strobe_n;
    // Merge only the strobed lanes; undriven data stores unknown
    task automatic store();
        logic [15:0] w;
        logic [15:0] d;
        w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
        d = data_io_oe ? data_io_out : 16'hxxxx;
        if (!lower_byte_col_strobe_n) w[7:0] = d[7:0];
        if (!upper_byte_col_strobe_n) w[15:8] = d[15:8];
        mem[{row, col}] = w;
    endtask : store
    // Sampled a little after the edge so same-edge address changes settle
    always @(negedge row_strobe_n) begin
        #1;
        if (col_n) row = mux_address;
    end
    // Late column latch keeps old page data briefly valid
    always @(negedge lower_byte_col_strobe_n or negedge upper_byte_col_strobe_n) begin
        #6;
        col = mux_address[7:0];
        if (!write_strobe_n && !row_strobe_n) store();
    end
    always @(negedge write_strobe_n) begin
        #1;
        if (!col_n && !row_strobe_n) store();
    end
    // Drive read data; open lanes and released bus show inverted old value
    always @(out_enable_n or write_strobe_n or col_n or row or col or last) begin
        rd = !out_enable_n && write_strobe_n && !col_n && !row_strobe_n;
        word = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
        if (lower_byte_col_strobe_n) word[7:0] = ~last[7:0];
        if (upper_byte_col_strobe_n) word[15:8] = ~last[15:8];
        data_io_in = rd ? word : ~last;
    end
    always @(negedge rd) last = word;
endmodule : pdwrr_dram_model

// File: dv/pdwrr_ctrl_tb.sv
// Self-checking bench for the page DRAM controller
module pdwrr_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_b, req_valid, req_ready, rsp_valid;
    pdwrr_pkg::pdwrr_req_t req;
    logic [15:0] rsp_rdata, data_io_in, data_io_out, q;
    logic self_refresh_req, self_refresh_active, init_done, data_io_oe;
    logic row_strobe_n, upper_byte_col_strobe_n, lower_byte_col_strobe_n;
    logic write_strobe_n, out_enable_n;
    logic [11:0] mux_address;
    int n_errors = 0;
    int checked = 0;
    // Short refresh interval so refreshes interleave with traffic
    pdwrr_ctrl #(.REF_CYC(100)) u_pdwrr_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .cken(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .self_refresh_req(self_refresh_req), .self_refresh_active(self_refresh_active),
        .init_done(init_done), .row_strobe_n(row_strobe_n),
        .upper_byte_col_strobe_n(upper_byte_col_strobe_n),
        .lower_byte_col_strobe_n(lower_byte_col_strobe_n), .write_strobe_n(write_strobe_n),
        .out_enable_n(out_enable_n), .mux_address(mux_address), .data_io_in(data_io_in),
        .data_io_out(data_io_out), .data_io_oe(data_io_oe)
    );
    pdwrr_dram_model u_pdwrr_dram_model (
        .row_strobe_n(row_strobe_n), .upper_byte_col_strobe_n(upper_byte_col_strobe_n),
        .lower_byte_col_strobe_n(lower_byte_col_strobe_n), .write_strobe_n(write_strobe_n),
        .out_enable_n(out_enable_n), .mux_address(mux_address), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .data_io_in(data_io_in)
    );
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Hold the request until taken; reads and RMW wait for their answer
    task automatic xfer(input logic w, rmw, keep, input logic [1:0] be,
                        input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        #1 req = '{w, rmw, keep, be, 12'h123, c, d};
        req_valid = 1'b1;
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        q = 16'hxxxx;
        if (!w || rmw) begin
            for (int i = 0; i < 12; i++) begin
                @(negedge core_clk);
                if (rsp_valid === 1'b1) begin
                    q = rsp_rdata;
                    break;
                end
            end
        end
    endtask : xfer
    // Word writes, then page reads of neighbouring columns
    task automatic t_word_page();
        xfer(1'b1, 1'b0, 1'b1, 2'b11, 8'h45, 16'ha5c3);
        xfer(1'b1, 1'b0, 1'b1, 2'b11, 8'h46, 16'h3c5a);
        xfer(1'b0, 1'b0, 1'b1, 2'b11, 8'h45, 16'h0000);
        chk("word read", 16'ha5c3, q);
        xfer(1'b0, 1'b0, 1'b0, 2'b11, 8'h46, 16'h0000);
        chk("page read", 16'h3c5a, q);
    endtask : t_word_page
    // Each byte strobe alters its own lane only
    task automatic t_bytes();
        xfer(1'b1, 1'b0, 1'b0, 2'b01, 8'h45, 16'h1177);
        xfer(1'b0, 1'b0, 1'b0, 2'b11, 8'h45, 16'h0000);
        chk("low lane write", 16'ha577, q);
        xfer(1'b1, 1'b0, 1'b0, 2'b10, 8'h45, 16'h22ff);
        xfer(1'b0, 1'b0, 1'b0, 2'b11, 8'h45, 16'h0000);
        chk("high lane write", 16'h2277, q);
    endtask : t_bytes
    // Read-modify-write hands back old data and stores the new
    task automatic t_rmw();
        xfer(1'b1, 1'b1, 1'b0, 2'b11, 8'h45, 16'h5aa5);
        chk("rmw old data", 16'h2277, q);
        xfer(1'b0, 1'b0, 1'b0, 2'b11, 8'h45, 16'h0000);
        chk("rmw new data", 16'h5aa5, q);
    endtask : t_rmw
    // Self refresh: requests refused inside, data kept across it
    task automatic t_self_refresh();
        #1 self_refresh_req = 1'b1;
        repeat (60) @(negedge core_clk);
        chk("self refresh entered", 16'h0001, {15'h0, self_refresh_active});
        chk("ready in self refresh", 16'h0000, {15'h0, req_ready});
        repeat (4100) @(posedge core_clk);
        #1 self_refresh_req = 1'b0;
        repeat (60) @(negedge core_clk);
        chk("self refresh left", 16'h0000, {15'h0, self_refresh_active});
        xfer(1'b0, 1'b0, 1'b0, 2'b11, 8'h46, 16'h0000);
        chk("data after refresh", 16'h3c5a, q);
    endtask : t_self_refresh
    task automatic finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 20000);
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        self_refresh_req = 1'b0;
        repeat (8) @(posedge core_clk);
        chk("pins in reset", 16'h001f, {11'h0, row_strobe_n, upper_byte_col_strobe_n,
            lower_byte_col_strobe_n, write_strobe_n, out_enable_n});
        #1 rst_b = 1'b1;
        repeat (200) @(negedge core_clk);
        chk("init done", 16'h0001, {15'h0, init_done});
        t_word_page();
        t_bytes();
        t_rmw();
        repeat (300) @(posedge core_clk);
        t_self_refresh();
        finish_test();
    end
endmodule : pdwrr_ctrl_tb
